// ### src/tbpp_pkg.sv
// Constants, register map and types of the transmit backplane port.
package tbpp_pkg;
    localparam int TBPP_AW = 7;
    localparam int TBPP_DW = 8;
    localparam int TBPP_CW = 5;
    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam logic [6:0] TBPP_REG_CFG   = 7'h00;
    localparam logic [6:0] TBPP_REG_BOFF  = 7'h01;
    localparam logic [6:0] TBPP_REG_TSOFF = 7'h02;
    localparam logic [6:0] TBPP_REG_STAT  = 7'h03;
    localparam logic [6:0] TBPP_REG_PCM   = 7'h40;
    localparam logic [6:0] TBPP_REG_SIG   = 7'h60;
    // ----------------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------------
    localparam int TBPP_CFG_RATE_LSB = 0;
    localparam int TBPP_CFG_RATE_MSB = 1;
    localparam int TBPP_CFG_E1       = 2;
    localparam int TBPP_CFG_FE       = 3;
    localparam int TBPP_CFG_DE       = 4;
    localparam int TBPP_CFG_FPIN     = 5;
    localparam int TBPP_CFG_CMS      = 6;
    localparam int TBPP_CFG_MAP      = 7;
    localparam int TBPP_BOFF_MSB     = 2;
    localparam int TBPP_BIT_OFFSET_ENABLE      = 3;
    localparam logic [7:0] TBPP_CFG_RATE_MASK = 8'h03;
    localparam logic [7:0] TBPP_CFG_RST   = 8'h20;
    localparam logic [7:0] TBPP_BOFF_RST  = 8'h00;
    localparam logic [6:0] TBPP_TSOFF_RST = 7'h00;
    // ----------------------------------------------------------------------
    // Framing and timing
    // ----------------------------------------------------------------------
    localparam logic [10:0] TBPP_T1_FRAME_BITS = 11'h0c1;
    localparam logic [10:0] TBPP_BASE_FRAME_BITS = 11'h100;
    localparam logic [6:0]  TBPP_BASE_SLOTS = 7'h20;
    localparam logic [4:0]  TBPP_T1_CHANNELS = 5'h18;
    localparam logic [4:0]  TBPP_LAST_SLOT = 5'h1f;
    localparam logic [2:0]  TBPP_LAST_BIT = 3'h7;
    localparam logic [2:0]  TBPP_EPB = 3'h2;
    localparam logic [2:0]  TBPP_EPB_CMS = 3'h4;
    localparam logic [4:0]  TBPP_FP_LATE_DIFF = 5'h01;
    localparam logic [4:0]  TBPP_FP_LEAD_DIFF = 5'h03;
    localparam logic [4:0]  TBPP_CER_BASE = 5'h04;
    localparam logic [4:0]  TBPP_CER_BASE_CMS = 5'h09;
    localparam logic [4:0]  TBPP_CER_STEP = 5'h02;
    typedef enum logic [1:0] {
        TBPP_R1544 = 2'b00,
        TBPP_R2048 = 2'b01,
        TBPP_R4096 = 2'b10,
        TBPP_R8192 = 2'b11
    } tbpp_rate_t;
    typedef enum logic {
        TBPP_HUNT = 1'b0,
        TBPP_RUN  = 1'b1
    } tbpp_state_t;
endpackage

// ### src/tbpp_sync.sv
// Two-stage synchroniser with an edge stage for the backplane pins.
`timescale 1ns/1ps
module tbpp_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Pins and synchronised view
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q_ff,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;

    if (W < 1) begin : g_chk
        $error("tbpp_sync needs W of at least one");
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            q_ff  <= '0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            q_ff  <= s2_ff;
        end
    end

    assign rise = s2_ff & ~q_ff;
    assign fall = ~s2_ff & q_ff;
endmodule // tbpp_sync

// ### src/tbpp_chan_mem.sv
// Channel byte memory with a registered read port shared with register reads.
`timescale 1ns/1ps
module tbpp_chan_mem #(
    parameter int AW = 5,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [15:0]   wr_data,
    // Read side
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    input  wire logic          rd_hi,
    input  wire logic          byp_en,
    input  wire logic [7:0]    byp_data,
    output logic      [7:0]    rd_data_ff
);
    logic [15:0] mem [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_chk
        $error("tbpp_chan_mem depth must be two to the power AW");
    end

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rd_data_ff <= 8'h00;
        else if (rd_en)
            rd_data_ff <= rd_hi ? mem[rd_addr][15:8] : mem[rd_addr][7:0];
        else if (byp_en)
            rd_data_ff <= byp_data;
        else
            rd_data_ff <= 8'h00;
    end
endmodule // tbpp_chan_mem

// ### src/tbpp_top.sv
// Transmit backplane receive port: PCM and signaling capture, frame pulse capture (input mode) or generation (output mode).
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tbpp_top (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // Register port
    input  wire logic [tbpp_pkg::TBPP_AW-1:0] reg_addr,
    input  wire logic [tbpp_pkg::TBPP_DW-1:0] reg_wr_data,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [tbpp_pkg::TBPP_DW-1:0] reg_rd_data,
    // Backplane link
    input  wire logic                         tx_backplane_clock,
    input  wire logic                         tx_backplane_frame_pulse_i,
    output logic                              tx_backplane_frame_pulse_o,
    output logic                              tx_backplane_frame_pulse_oe,
    input  wire logic                         tx_backplane_pcm_data,
    input  wire logic                         tx_backplane_signaling
);
    import tbpp_pkg::*;

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [4:0] tbpp_delay(input logic ben, input logic [2:0] bv,
                                             input logic clock_multiple_select, input logic diff);
        logic [4:0] base;
        base = clock_multiple_select ? TBPP_CER_BASE_CMS : TBPP_CER_BASE;
        if (ben)
            return base + TBPP_CER_STEP * {2'b00, bv};
        return diff ? TBPP_FP_LATE_DIFF : 5'h00;
    endfunction

    function automatic logic [10:0] tbpp_frame_bits(input logic [1:0] rate, input logic e1);
        if (rate == TBPP_R1544 && !e1)
            return TBPP_T1_FRAME_BITS;
        if (rate == TBPP_R1544)
            return TBPP_BASE_FRAME_BITS;
        return TBPP_BASE_FRAME_BITS << (rate - 2'b01);
    endfunction

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    logic [7:0]  cfg_ff;
    logic [7:0]  boff_ff;
    logic [6:0]  tsoff_ff;
    logic        rate_locked_ff;
    logic [1:0]  rate;
    logic        e1, fe, de, fp_in, clock_multiple_select, map_on, bit_offset_enable, diff;
    logic [2:0]  boff_val;

    assign rate     = cfg_ff[TBPP_CFG_RATE_MSB:TBPP_CFG_RATE_LSB];
    assign e1       = cfg_ff[TBPP_CFG_E1];
    assign fe       = cfg_ff[TBPP_CFG_FE];
    assign de       = cfg_ff[TBPP_CFG_DE];
    assign fp_in    = cfg_ff[TBPP_CFG_FPIN];
    assign clock_multiple_select      = cfg_ff[TBPP_CFG_CMS];
    assign map_on   = cfg_ff[TBPP_CFG_MAP];
    assign bit_offset_enable  = boff_ff[TBPP_BIT_OFFSET_ENABLE];
    assign boff_val = boff_ff[TBPP_BOFF_MSB:0];
    assign diff     = fe != de;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cfg_ff         <= TBPP_CFG_RST;
            boff_ff        <= TBPP_BOFF_RST;
            tsoff_ff       <= TBPP_TSOFF_RST;
            rate_locked_ff <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                TBPP_REG_CFG:
                begin
                    if (rate_locked_ff)
                        cfg_ff <= (reg_wr_data & ~TBPP_CFG_RATE_MASK)
                                  | (cfg_ff & TBPP_CFG_RATE_MASK);
                    else
                        cfg_ff <= reg_wr_data;
                    rate_locked_ff <= 1'b1;
                end
                TBPP_REG_BOFF:  boff_ff  <= reg_wr_data;
                TBPP_REG_TSOFF: tsoff_ff <= reg_wr_data[6:0];
                default:        cfg_ff   <= cfg_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Link sampling
    // ----------------------------------------------------------------------
    logic [3:0] lnk, lnk_rise, lnk_fall;
    logic       edge_any, de_edge, fe_edge;
    logic [2:0] epb;

    tbpp_sync #(.W(4)) u_sync (
        .clk  (clk),
        .rst_b(rst_b),
        .din  ({tx_backplane_signaling, tx_backplane_pcm_data,
                tx_backplane_frame_pulse_i, tx_backplane_clock}),
        .q_ff (lnk),
        .rise (lnk_rise),
        .fall (lnk_fall)
    );

    assign edge_any = lnk_rise[0] | lnk_fall[0];
    assign de_edge  = de ? lnk_rise[0] : lnk_fall[0];
    assign fe_edge  = fe ? lnk_rise[0] : lnk_fall[0];
    assign epb      = clock_multiple_select ? TBPP_EPB_CMS : TBPP_EPB;

    // ----------------------------------------------------------------------
    // Frame alignment
    // ----------------------------------------------------------------------
    tbpp_state_t state_ff, nxt_state;
    logic        fp_prev_ff, fp_evt, active, samp_now, first_samp;
    logic [12:0] fcnt_ff, frame_edges, rise_at;
    logic [4:0]  dly, cnt_ff, eff_cnt;
    logic [10:0] bit_ff, eff_bit, fbits;
    logic [5:0]  frame_cnt_ff;

    assign dly         = tbpp_delay(bit_offset_enable, boff_val, clock_multiple_select, diff);
    assign fbits       = tbpp_frame_bits(rate, e1);
    assign frame_edges = 13'(fbits) * 13'(epb);
    assign rise_at     = 13'((frame_edges + 13'(dly) - 13'(diff ? TBPP_FP_LEAD_DIFF : 5'h00))
                             % frame_edges);

    always_comb
    begin
        if (fp_in)
            fp_evt = fe_edge && lnk[1] && !fp_prev_ff;
        else if (state_ff == TBPP_HUNT)
            fp_evt = fe_edge;
        else
            fp_evt = edge_any && fcnt_ff == 13'h0000;
        nxt_state = fp_evt ? TBPP_RUN : state_ff;
    end

    assign active     = state_ff == TBPP_RUN || fp_evt;
    assign eff_cnt    = fp_evt ? dly : cnt_ff;
    assign eff_bit    = fp_evt ? 11'h000 : bit_ff;
    assign samp_now   = edge_any && active && eff_cnt == 5'h00;
    assign first_samp = samp_now && eff_bit == 11'h000;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_ff     <= TBPP_HUNT;
            fp_prev_ff   <= 1'b0;
            frame_cnt_ff <= 6'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            if (fe_edge)
                fp_prev_ff <= lnk[1];
            if (fp_evt)
                frame_cnt_ff <= frame_cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_ff <= 5'h00;
            bit_ff <= 11'h000;
        end
        else if (edge_any && active)
        begin
            if (eff_cnt == 5'h00)
            begin
                cnt_ff <= 5'({2'b00, epb} - 5'h01);
                bit_ff <= (eff_bit == fbits - 11'h001) ? 11'h000 : eff_bit + 11'h001;
            end
            else
            begin
                cnt_ff <= eff_cnt - 5'h01;
                bit_ff <= eff_bit;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Frame pulse output
    // ----------------------------------------------------------------------
    logic [2:0] fpw_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fcnt_ff                     <= 13'h0000;
            fpw_ff                      <= 3'h0;
            tx_backplane_frame_pulse_o  <= 1'b0;
            tx_backplane_frame_pulse_oe <= 1'b0;
        end
        else
        begin
            tx_backplane_frame_pulse_oe <= !fp_in;
            if (edge_any)
            begin
                if (state_ff == TBPP_HUNT)
                    fcnt_ff <= 13'h0001;
                else
                    fcnt_ff <= (fcnt_ff == frame_edges - 13'h0001) ? 13'h0000
                                                                   : fcnt_ff + 13'h0001;
                if (!fp_in && state_ff == TBPP_RUN && fcnt_ff == rise_at)
                begin
                    tx_backplane_frame_pulse_o <= 1'b1;
                    fpw_ff                     <= epb - 3'h1;
                end
                else if (fpw_ff != 3'h0)
                    fpw_ff <= fpw_ff - 3'h1;
                else
                    tx_backplane_frame_pulse_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Timeslot mapping
    // ----------------------------------------------------------------------
    logic [7:0]  pcm_sh_ff, sig_sh_ff;
    logic        fbit_ff, keep, is_f, mem_we;
    logic [4:0]  chan, slot;
    logic [2:0]  pos;
    logic [6:0]  eslot, smask, lmask;
    logic [10:0] k;
    logic [1:0]  sh;

    always_comb
    begin
        sh    = (rate == TBPP_R1544) ? 2'b00 : rate - 2'b01;
        smask = (TBPP_BASE_SLOTS << sh) - 7'h01;
        lmask = (7'h01 << sh) - 7'h01;
        k     = eff_bit - 11'h001;
        eslot = (eff_bit[9:3] - tsoff_ff) & smask;
        pos   = eff_bit[2:0];
        slot  = 5'(eslot >> sh);
        keep  = (eslot & lmask) == 7'h00;
        is_f  = 1'b0;
        chan  = slot;
        if (rate == TBPP_R1544 && !e1)
        begin
            pos  = k[2:0];
            chan = k[7:3];
            is_f = eff_bit == 11'h000;
            keep = !is_f;
        end
        else if (!e1 && !map_on)
        begin
            is_f = keep && slot == 5'h00 && pos == 3'h0;
            keep = keep && slot[1:0] != 2'b00;
            chan = slot - (slot >> 2) - 5'h01;
        end
        else if (!e1)
        begin
            is_f = keep && slot == TBPP_LAST_SLOT && pos == TBPP_LAST_BIT;
            keep = keep && slot < TBPP_T1_CHANNELS;
        end
        mem_we = samp_now && keep && pos == TBPP_LAST_BIT;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pcm_sh_ff <= 8'h00;
            sig_sh_ff <= 8'h00;
            fbit_ff   <= 1'b0;
        end
        else if (samp_now)
        begin
            pcm_sh_ff <= {pcm_sh_ff[6:0], lnk[2]};
            sig_sh_ff <= {sig_sh_ff[6:0], lnk[3]};
            if (is_f)
                fbit_ff <= lnk[2];
        end
    end

    // ----------------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------------
    logic [7:0] byp_data;

    always_comb
    begin
        case (reg_addr)
            TBPP_REG_CFG:   byp_data = cfg_ff;
            TBPP_REG_BOFF:  byp_data = boff_ff;
            TBPP_REG_TSOFF: byp_data = {1'b0, tsoff_ff};
            TBPP_REG_STAT:  byp_data = {state_ff == TBPP_RUN, fbit_ff, frame_cnt_ff};
            default:        byp_data = 8'h00;
        endcase
    end

    tbpp_chan_mem #(.AW(TBPP_CW), .DEPTH(32)) u_mem (
        .clk       (clk),
        .rst_b     (rst_b),
        .wr_en     (mem_we),
        .wr_addr   (chan),
        .wr_data   ({sig_sh_ff[6:0], lnk[3], pcm_sh_ff[6:0], lnk[2]}),
        .rd_en     (reg_rd && reg_addr >= TBPP_REG_PCM),
        .rd_addr   (reg_addr[4:0]),
        .rd_hi     (reg_addr >= TBPP_REG_SIG),
        .byp_en    (reg_rd),
        .byp_data  (byp_data),
        .rd_data_ff(reg_rd_data)
    );

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    logic [4:0] ec_ff;
    logic [2:0] er_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ec_ff <= 5'h00;
            er_ff <= 3'h0;
        end
        else if (edge_any)
        begin
            ec_ff <= fp_evt ? 5'h00 : (ec_ff == 5'h1f ? ec_ff : ec_ff + 5'h01);
            er_ff <= (!fp_in && state_ff == TBPP_RUN && fcnt_ff == rise_at) ? 3'h0
                     : (er_ff == 3'h7 ? er_ff : er_ff + 3'h1);
        end
    end

    sequence s_cfg_write;
        reg_wr && reg_addr == TBPP_REG_CFG;
    endsequence

    sequence s_first_direct;
        first_samp && !bit_offset_enable && !e1;
    endsequence

    a_rate_locked_keep: assert property (@(posedge clk) disable iff (!rst_b)
        s_cfg_write ##0 rate_locked_ff |=> $stable(rate))
        else $error("rate changed after first configuration write");
    a_fp_oe_dir: assert property (@(posedge clk) disable iff (!rst_b)
        s_cfg_write ##0 !reg_wr_data[TBPP_CFG_FPIN] ##1 !reg_wr |=> tx_backplane_frame_pulse_oe)
        else $error("frame pulse not driven in output mode");
    a_same_edge_fp: assert property (@(posedge clk) disable iff (!rst_b)
        s_first_direct ##0 fp_in && !diff |-> fp_evt)
        else $error("first data not sampled on the frame pulse edge");
    a_diff_edge_fp: assert property (@(posedge clk) disable iff (!rst_b)
        s_first_direct ##0 fp_in && diff |-> !fp_evt && ec_ff == 5'h00)
        else $error("first data not one edge after the frame pulse");
    a_bit_offset_cer: assert property (@(posedge clk) disable iff (!rst_b)
        first_samp && bit_offset_enable && !fp_evt |-> ec_ff + 5'h01 == dly)
        else $error("first data not at the bit offset edge count");
    a_fp_out_same: assert property (@(posedge clk) disable iff (!rst_b)
        s_first_direct ##0 !fp_in && !diff && frame_cnt_ff > 6'h00
        |=> $rose(tx_backplane_frame_pulse_o))
        else $error("output frame pulse not updated on the data edge");
    a_fp_out_lead: assert property (@(posedge clk) disable iff (!rst_b)
        s_first_direct ##0 !fp_in && diff && frame_cnt_ff > 6'h00 |-> er_ff == 3'h2)
        else $error("output frame pulse not three edges before data");
    a_data_edge_pol: assert property (@(posedge clk) disable iff (!rst_b)
        samp_now |=> (de ? $rose(lnk[0]) : $fell(lnk[0])))
        else $error("data sampled on the wrong clock edge");
    a_t1_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
        mem_we && !e1 && !map_on && rate != TBPP_R1544
        |-> slot[1:0] != 2'b00 && chan < TBPP_T1_CHANNELS)
        else $error("unused timeslot stored");
    a_t1_mapped: assert property (@(posedge clk) disable iff (!rst_b)
        mem_we && !e1 && map_on && rate != TBPP_R1544 |-> chan < TBPP_T1_CHANNELS)
        else $error("mapped channel beyond slot 23 stored");
endmodule // tbpp_top

// ### test/tbpp_bp_model.sv
// Behavioural backplane source that drives frames into the port.
`timescale 1ns/1ps
module tbpp_bp_model (
    // Backplane pins
    output logic bp_clk,
    output logic fp,
    output logic pcm,
    output logic sig
);
    // ------------------------------------------------------------------
    // Frame source
    // ------------------------------------------------------------------
    initial
    begin
        bp_clk = 1'b0;
        fp     = 1'b0;
        pcm    = 1'b0;
        sig    = 1'b1;
    end

    // Sends 32 slots; the clock stands still and lines invert afterwards.
    task automatic send_frame(input logic [7:0] slot [32]);
        for (int s = 0; s < 32; s++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                fp  = (s == 0) && (b == 0);
                pcm = slot[s][7-b];
                sig = ~slot[s][7-b];
                #100 bp_clk = 1'b1;
                #100 bp_clk = 1'b0;
            end
        end
        fp  = 1'b0;
        pcm = ~pcm;
        sig = ~sig;
    endtask
endmodule // tbpp_bp_model

// ### test/test_tbpp_top.sv
// Self-checking testbench of the transmit backplane port.
`timescale 1ns/1ps
module test_tbpp_top;
    import tbpp_pkg::*;
    logic       clk, rst_b, reg_wr, reg_rd, rd_seen;
    logic [6:0] reg_addr;
    logic [7:0] reg_wr_data, reg_rd_data;
    logic       bp_clk, fp_i, fp_o, fp_oe, pcm, sig;
    logic [7:0] slot [32];
    logic [7:0] exp_q [$];
    int         failures, total_checks, fp_pulses;
    integer     seed;

    tbpp_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .tx_backplane_clock(bp_clk),
        .tx_backplane_frame_pulse_i(fp_i), .tx_backplane_frame_pulse_o(fp_o),
        .tx_backplane_frame_pulse_oe(fp_oe), .tx_backplane_pcm_data(pcm),
        .tx_backplane_signaling(sig));
    tbpp_bp_model u_bp (.bp_clk(bp_clk), .fp(fp_i), .pcm(pcm), .sig(sig));

    // ------------------------------------------------------------------
    // Clock, bus tasks and checking
    // ------------------------------------------------------------------
    always #12.5 clk = ~clk;

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr      <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // Resets the port, sets up one mode and sends two frames of fresh bytes.
    task automatic run_mode(input logic [7:0] cfg);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        wr(TBPP_REG_CFG, cfg);
        for (int s = 0; s < 32; s++)
            slot[s] = 8'($random(seed));
        repeat (2) u_bp.send_frame(slot);
        repeat (8) @(posedge clk);
    endtask

    // Counts the frame pulses that the port drives in output mode.
    always @(posedge fp_o)
        fp_pulses++;

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk)
    begin
        if (rd_seen)
            cmp(reg_rd_data, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    task conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk          = 1'b0;
        rst_b        = 1'b0;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = 7'h00;
        reg_wr_data  = 8'h00;
        rd_seen      = 1'b0;
        seed         = 9;
        failures     = 0;
        total_checks = 0;
        fp_pulses    = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(TBPP_REG_CFG, TBPP_CFG_RST);
        rd(TBPP_REG_BOFF, TBPP_BOFF_RST);
        rd(TBPP_REG_TSOFF, {1'b0, TBPP_TSOFF_RST});
        rd(7'h10, 8'h00);
        wr(TBPP_REG_CFG, 8'h3d);
        wr(TBPP_REG_CFG, 8'h3c);
        rd(TBPP_REG_CFG, 8'h3d);
        @(negedge clk);
        cmp({7'h00, fp_oe}, 8'h00);
        for (int s = 0; s < 32; s++)
            slot[s] = 8'($random(seed));
        repeat (2) u_bp.send_frame(slot);
        repeat (8) @(posedge clk);
        for (int s = 0; s < 32; s++)
        begin
            rd(TBPP_REG_PCM | 7'(s), slot[s]);
            rd(TBPP_REG_SIG | 7'(s), ~slot[s]);
        end
        rd(TBPP_REG_STAT, 8'h82);
        run_mode(8'hb9);
        for (int s = 0; s < 24; s++)
            rd(TBPP_REG_PCM | 7'(s), slot[s]);
        rd(TBPP_REG_STAT, {1'b1, slot[31][0], 6'h02});
        run_mode(8'h19);
        for (int s = 1; s < 32; s++)
            if (s % 4 != 0)
                rd(TBPP_REG_PCM | 7'(s - s / 4 - 1), slot[s]);
        rd(TBPP_REG_STAT, {1'b1, slot[0][7], 6'h02});
        @(negedge clk);
        cmp({7'h00, fp_oe}, 8'h01);
        cmp(8'(fp_pulses), 8'h01);
        repeat (4) @(posedge clk);
        conclude;
    end

    // Cuts a hang short well after the expected run of about 13000 cycles.
    initial
    begin
        #800000;
        failures++;
        conclude;
    end
endmodule // test_tbpp_top
